// ==== inc/ssb_pkg.sv ====
/*
 Package for the safety axis status bank: register offsets, field positions,
 reset values and encodings.
 Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
*/
// Overview of operation
// - Safe acceleration readable per axis, valid only with a safe encoder.
// - Read-only 32-bit active-function word, one bit per function, resets zero.
// - Bit 0 reads 1 while safe torque removal is active.
// - Bits 1 and 2 flag speed monitor instances one and two in range.
// - Bit 3 reads 1 while safe operating stop is active.
// - Bits 4, 13, 14 flag speed range instances one to three limiting.
// - Bit 5 positive direction, bit 6 negative direction motion.
// - Bit 7 reads 1 while a safety error is active.
// - Bits 8, 9, 10 flag safe cam instances inside limits.
// - Bit 11 reads 1 while limited acceleration is held.
// - Bits 30, 31, 12 flag accel range instances one to three limiting.
// - Bits 16, 17, 18 flag limited speed instances holding limit.
// - Bits 19, 20, 21 flag stop type one instances active.
// - Bits 22, 23 flag stop type two instances active.
// - Bits 24-26 limited increment, bits 27-29 limited position instances.
// - Brake state 0 engaged, 1 releasing, 2 released, 3 engaging; resets engaged.
// - Error flag reads 1 while in error, 0 otherwise.
// - Application parameter length 0 for tool parameters, 4 over fieldbus.
// - Communication parameter length always reads 2.
// - Master assigns identifier 1 to 65535; stored, reported once connected.
// - Connection type reads constant 2, a slave.
// - Last error codes 0 to 5: reset, unexpected, unknown, id, checksum, watchdog.
// - Codes 6 to 11: address, safety data, comm and appl length or data.
package ssb_pkg;
   // ************************************
   // Register byte offsets
   // ************************************
   localparam logic [7:0] SSB_OFS_ACCEL = 8'h00;
   localparam logic [7:0] SSB_OFS_ACTIVE = 8'h04;
   localparam logic [7:0] SSB_OFS_BRAKE = 8'h08;
   localparam logic [7:0] SSB_OFS_ERROR = 8'h0c;
   localparam logic [7:0] SSB_OFS_APPL_LEN = 8'h10;
   localparam logic [7:0] SSB_OFS_COMM_LEN = 8'h14;
   localparam logic [7:0] SSB_OFS_CONN_ID = 8'h18;
   localparam logic [7:0] SSB_OFS_CONN_KIND = 8'h1c;
   localparam logic [7:0] SSB_OFS_LAST_ERR = 8'h20;
   localparam logic [7:0] SSB_OFS_PROTO_VER = 8'h24;
   localparam logic [7:0] SSB_OFS_ACCEL_VALID = 8'h28;
   // ************************************
   // Active-function word fields
   // ************************************
   localparam int SSB_BIT_TORQUE_OFF = 0;
   localparam int SSB_BIT_SPEED_MON1 = 1;
   localparam int SSB_BIT_SPEED_MON2 = 2;
   localparam int SSB_BIT_OPER_STOP = 3;
   localparam int SSB_BIT_SPEED_RNG1 = 4;
   localparam int SSB_BIT_DIR_POS = 5;
   localparam int SSB_BIT_DIR_NEG = 6;
   localparam int SSB_BIT_ERROR = 7;
   localparam int SSB_BIT_CAM1 = 8;
   localparam int SSB_BIT_LIM_ACCEL = 11;
   localparam int SSB_BIT_ACC_RNG3 = 12;
   localparam int SSB_BIT_SPEED_RNG2 = 13;
   localparam int SSB_BIT_UNUSED = 15;
   localparam int SSB_BIT_LIM_SPEED1 = 16;
   localparam int SSB_BIT_STOP1_1 = 19;
   localparam int SSB_BIT_STOP2_1 = 22;
   localparam int SSB_BIT_LIM_INCR1 = 24;
   localparam int SSB_BIT_LIM_POS1 = 27;
   localparam int SSB_BIT_ACC_RNG1 = 30;
   // ************************************
   // Reset values and constants
   // ************************************
   localparam logic [31:0] SSB_ACTIVE_RST = 32'h0000_0000;
   localparam logic [15:0] SSB_APPL_LEN_TOOL = 16'h0000;
   localparam logic [15:0] SSB_APPL_LEN_BUS = 16'h0004;
   localparam logic [15:0] SSB_COMM_LEN = 16'h0002;
   localparam logic [7:0] SSB_CONN_KIND_SLAVE = 8'h02;
   localparam logic [15:0] SSB_CONN_ID_RST = 16'h0000;
   localparam logic [7:0] SSB_LAST_ERR_RST = 8'h00;
   localparam logic [1:0] SSB_RESP_OKAY = 2'b00;
   localparam logic [1:0] SSB_RESP_SLVERR = 2'b10;
   localparam logic [1:0] SSB_RESP_DECERR = 2'b11;
   // Brake state machine states
   typedef enum logic [1:0] {
      SSB_BRK_ENGAGED = 2'h0,
      SSB_BRK_RELEASING = 2'h1,
      SSB_BRK_RELEASED = 2'h2,
      SSB_BRK_ENGAGING = 2'h3
   } ssb_brake_e;
   // Last link error codes
   typedef enum logic [7:0] {
      SSB_ERR_RESET = 8'h00,
      SSB_ERR_UNEXP_CMD = 8'h01,
      SSB_ERR_UNKNOWN_CMD = 8'h02,
      SSB_ERR_BAD_CONN_ID = 8'h03,
      SSB_ERR_CHECKSUM = 8'h04,
      SSB_ERR_WATCHDOG = 8'h05,
      SSB_ERR_BAD_ADDR = 8'h06,
      SSB_ERR_BAD_DATA = 8'h07,
      SSB_ERR_COMM_LEN = 8'h08,
      SSB_ERR_COMM_DATA = 8'h09,
      SSB_ERR_APPL_LEN = 8'h0a,
      SSB_ERR_APPL_DATA = 8'h0b
   } ssb_link_err_e;
endpackage

// ==== logic/ssb_inst_vec.sv ====
/*
 Qualifies a vector of function-instance status levels into register bits.
 Assumes status inputs synchronous to the clock.
*/
`timescale 1ns/1ns
module ssb_inst_vec
   import ssb_pkg::*;
#(
   parameter int N = 3
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [N-1:0] i_status,
   output logic [N-1:0] o_flags
);
   // Registered so the bank word is coherent within one cycle
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flags <= '0;
      end else begin
         o_flags <= i_status;
      end
   end
endmodule

// ==== logic/ssb_link_state.sv ====
/*
 Holds the fieldbus link values set by the safety master side.
 Assumes single-cycle strobes from the link protocol engine.
*/
`timescale 1ns/1ns
module ssb_link_state
   import ssb_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_conn_reached,
   input wire logic i_conn_id_valid,
   input wire logic [15:0] i_conn_id,
   input wire logic i_link_err_valid,
   input wire logic [7:0] i_link_err,
   output logic [15:0] o_conn_id,
   output logic [7:0] o_last_err
);
   // Zero is never legal, so out-of-range ids are dropped
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_conn_id <= SSB_CONN_ID_RST;
      end else if (i_conn_reached && i_conn_id_valid &&
                   i_conn_id != 16'h0000) begin
         o_conn_id <= i_conn_id;
      end
   end

   // Codes above the defined set are stored as given
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_last_err <= SSB_LAST_ERR_RST;
      end else if (i_link_err_valid) begin
         o_last_err <= i_link_err;
      end
   end
endmodule

// ==== logic/ssb_status_bank.sv ====
/*
 Safety axis status bank: read-only registers behind an AXI4-Lite slave.
 Assumes status inputs synchronous to i_ref_clk; writes never change state.
*/
`timescale 1ns/1ns
module ssb_status_bank
   import ssb_pkg::*;
#(
   parameter logic [15:0] PROTO_VER = 16'h0001 // Arbitrary value
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // AXI4-Lite slave
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // Safety function status levels
   input wire logic [31:0] i_safe_accel,
   input wire logic i_safe_encoder_present,
   input wire logic i_safe_torque_removal,
   input wire logic [1:0] i_safe_speed_monitor,
   input wire logic i_safe_operating_stop,
   input wire logic [2:0] i_safe_speed_range,
   input wire logic i_direction_positive,
   input wire logic i_direction_negative,
   input wire logic i_safety_error,
   input wire logic [2:0] i_safe_cam,
   input wire logic i_limited_acceleration,
   input wire logic [2:0] i_safe_accel_range,
   input wire logic [2:0] i_limited_speed,
   input wire logic [2:0] i_stop_type_one,
   input wire logic [1:0] i_stop_type_two,
   input wire logic [2:0] i_limited_increment,
   input wire logic [2:0] i_limited_position,
   input wire logic [1:0] i_safe_brake_ctrl_state,
   // Fieldbus link side
   input wire logic i_appl_param_over_bus,
   input wire logic i_conn_reached,
   input wire logic i_conn_id_valid,
   input wire logic [15:0] i_conn_id,
   input wire logic i_link_err_valid,
   input wire logic [7:0] i_link_err
);
   // ************************************
   // Declarations
   // ************************************
   logic [2:0] speed_range_q;
   logic [2:0] cam_q;
   logic [2:0] accel_range_q;
   logic [2:0] lim_speed_q;
   logic [2:0] stop1_q;
   logic [2:0] lim_incr_q;
   logic [2:0] lim_pos_q;
   logic [1:0] speed_mon_q;
   logic [1:0] stop2_q;
   logic [15:0] conn_id;
   logic [7:0] last_err;
   logic [31:0] accel_q;
   logic accel_valid_q;
   logic [5:0] single_q;
   logic [31:0] active_d;
   ssb_brake_e brake_q;
   logic error_q;
   logic appl_bus_q;
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic ar_busy;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   // ************************************
   // Instance status capture
   // ************************************
   ssb_inst_vec #(.N(3)) u_speed_range (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_safe_speed_range), .o_flags(speed_range_q));
   ssb_inst_vec #(.N(3)) u_cam (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_safe_cam), .o_flags(cam_q));
   ssb_inst_vec #(.N(3)) u_accel_range (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_safe_accel_range), .o_flags(accel_range_q));
   ssb_inst_vec #(.N(3)) u_lim_speed (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_limited_speed), .o_flags(lim_speed_q));
   ssb_inst_vec #(.N(3)) u_stop1 (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_stop_type_one), .o_flags(stop1_q));
   ssb_inst_vec #(.N(3)) u_lim_incr (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_limited_increment), .o_flags(lim_incr_q));
   ssb_inst_vec #(.N(3)) u_lim_pos (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_limited_position), .o_flags(lim_pos_q));
   ssb_inst_vec #(.N(2)) u_speed_mon (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_safe_speed_monitor), .o_flags(speed_mon_q));
   ssb_inst_vec #(.N(2)) u_stop2 (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status(i_stop_type_two), .o_flags(stop2_q));
   // Single-bit sources take the same one register stage as instances
   ssb_inst_vec #(.N(6)) u_single (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_status({i_limited_acceleration, i_safety_error,
                 i_direction_negative, i_direction_positive,
                 i_safe_operating_stop, i_safe_torque_removal}),
      .o_flags(single_q));

   ssb_link_state u_link (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_conn_reached(i_conn_reached),
      .i_conn_id_valid(i_conn_id_valid),
      .i_conn_id(i_conn_id),
      .i_link_err_valid(i_link_err_valid),
      .i_link_err(i_link_err),
      .o_conn_id(conn_id),
      .o_last_err(last_err));

   // ************************************
   // Active-function word
   // ************************************
   always_comb begin
      active_d = SSB_ACTIVE_RST;
      active_d[SSB_BIT_TORQUE_OFF] = single_q[0];
      active_d[SSB_BIT_SPEED_MON1 +: 2] = speed_mon_q;
      active_d[SSB_BIT_OPER_STOP] = single_q[1];
      active_d[SSB_BIT_SPEED_RNG1] = speed_range_q[0];
      active_d[SSB_BIT_SPEED_RNG2 +: 2] = speed_range_q[2:1];
      active_d[SSB_BIT_DIR_POS] = single_q[2];
      active_d[SSB_BIT_DIR_NEG] = single_q[3];
      active_d[SSB_BIT_ERROR] = single_q[4];
      active_d[SSB_BIT_CAM1 +: 3] = cam_q;
      active_d[SSB_BIT_LIM_ACCEL] = single_q[5];
      active_d[SSB_BIT_ACC_RNG1 +: 2] = accel_range_q[1:0];
      active_d[SSB_BIT_ACC_RNG3] = accel_range_q[2];
      active_d[SSB_BIT_LIM_SPEED1 +: 3] = lim_speed_q;
      active_d[SSB_BIT_STOP1_1 +: 3] = stop1_q;
      active_d[SSB_BIT_STOP2_1 +: 2] = stop2_q;
      active_d[SSB_BIT_LIM_INCR1 +: 3] = lim_incr_q;
      active_d[SSB_BIT_LIM_POS1 +: 3] = lim_pos_q;
      active_d[SSB_BIT_UNUSED] = 1'b0;
   end

   // ************************************
   // Axis values
   // ************************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         accel_q <= 32'h0000_0000;
         accel_valid_q <= 1'b0;
      end else begin
         // Without a safe encoder the value is invalid and reads zero
         accel_valid_q <= i_safe_encoder_present;
         accel_q <= i_safe_encoder_present ? i_safe_accel : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         brake_q <= SSB_BRK_ENGAGED;
      end else begin
         brake_q <= ssb_brake_e'(i_safe_brake_ctrl_state);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         error_q <= 1'b0;
         appl_bus_q <= 1'b0;
      end else begin
         error_q <= i_safety_error;
         appl_bus_q <= i_appl_param_over_bus;
      end
   end

   // ************************************
   // Write channel: accepted and answered, never stored
   // ************************************
   assign o_s_axi_awready = !aw_held_q && !o_s_axi_bvalid;
   assign o_s_axi_wready = !w_held_q && !o_s_axi_bvalid;

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= SSB_RESP_OKAY;
      end else if (o_s_axi_bvalid) begin
         if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
      end else if ((aw_held_q || i_s_axi_awvalid) &&
                   (w_held_q || i_s_axi_wvalid)) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         o_s_axi_bvalid <= 1'b1;
         // Mapped but read-only: slave error, contents untouched
         o_s_axi_bresp <= wr_hit ? SSB_RESP_SLVERR : SSB_RESP_DECERR;
      end else begin
         if (i_s_axi_awvalid) begin
            aw_held_q <= 1'b1;
            awaddr_q <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid) begin
            w_held_q <= 1'b1;
         end
      end
   end

   always_comb begin
      logic [7:0] a;
      a = aw_held_q ? awaddr_q : i_s_axi_awaddr;
      wr_hit = a[1:0] == 2'b00 && a <= SSB_OFS_ACCEL_VALID;
   end

   // ************************************
   // Read channel
   // ************************************
   assign ar_busy = o_s_axi_rvalid;
   assign o_s_axi_arready = !ar_busy;

   always_comb begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      case (i_s_axi_araddr)
         SSB_OFS_ACCEL: rd_word = accel_q;
         SSB_OFS_ACTIVE: rd_word = active_d;
         SSB_OFS_BRAKE: rd_word = {30'h0000_0000, brake_q};
         SSB_OFS_ERROR: rd_word = {31'h0000_0000, error_q};
         SSB_OFS_APPL_LEN: begin
            rd_word = {16'h0000,
                       appl_bus_q ? SSB_APPL_LEN_BUS : SSB_APPL_LEN_TOOL};
         end
         SSB_OFS_COMM_LEN: rd_word = {16'h0000, SSB_COMM_LEN};
         SSB_OFS_CONN_ID: rd_word = {16'h0000, conn_id};
         SSB_OFS_CONN_KIND: rd_word = {24'h00_0000, SSB_CONN_KIND_SLAVE};
         SSB_OFS_LAST_ERR: rd_word = {24'h00_0000, last_err};
         SSB_OFS_PROTO_VER: rd_word = {16'h0000, PROTO_VER};
         SSB_OFS_ACCEL_VALID: rd_word = {31'h0000_0000, accel_valid_q};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h0000_0000;
         o_s_axi_rresp <= SSB_RESP_OKAY;
      end else if (o_s_axi_rvalid) begin
         if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
         end
      end else if (i_s_axi_arvalid) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_word;
         o_s_axi_rresp <= rd_hit ? SSB_RESP_OKAY : SSB_RESP_DECERR;
      end
   end
endmodule

// ==== tb/ssb_status_bank_props.sv ====
/*
 Checker for the safety axis status bank, bound to the top module ports.
 Assumes one clock domain and status inputs held steady around reads.
*/
`timescale 1ns/1ns
module ssb_status_bank_props
   import ssb_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic [1:0] o_s_axi_rresp,
   input wire logic o_s_axi_rvalid,
   input wire logic i_safe_encoder_present,
   input wire logic i_safe_torque_removal,
   input wire logic i_safety_error,
   input wire logic [1:0] i_safe_brake_ctrl_state,
   input wire logic i_appl_param_over_bus,
   input wire logic i_link_err_valid,
   input wire logic [7:0] i_link_err
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   // ************************************
   // Read and write checks
   // ************************************
   sequence s_rd(logic [7:0] a);
      i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == a;
   endsequence
   a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
      |=> o_s_axi_rvalid) else $error("read not answered");
   a_torque_bit: assert property (
      s_rd(SSB_OFS_ACTIVE) ##0 $stable(i_safe_torque_removal)
      |=> o_s_axi_rdata[0] == $past(i_safe_torque_removal))
      else $error("torque removal bit wrong");
   a_unused_bit: assert property (
      s_rd(SSB_OFS_ACTIVE) |=> !o_s_axi_rdata[15])
      else $error("unused bit set");
   a_error_flag: assert property (
      s_rd(SSB_OFS_ERROR) ##0 $stable(i_safety_error)
      |=> o_s_axi_rdata == {31'h0, $past(i_safety_error)})
      else $error("error flag wrong");
   a_brake_state: assert property (
      s_rd(SSB_OFS_BRAKE) ##0 $stable(i_safe_brake_ctrl_state)
      |=> o_s_axi_rdata == {30'h0, $past(i_safe_brake_ctrl_state)})
      else $error("brake state wrong");
   a_comm_len: assert property (
      s_rd(SSB_OFS_COMM_LEN) |=> o_s_axi_rdata == 32'h0000_0002
      && o_s_axi_rresp == SSB_RESP_OKAY) else $error("comm length wrong");
   a_conn_kind: assert property (
      s_rd(SSB_OFS_CONN_KIND) |=> o_s_axi_rdata == 32'h0000_0002)
      else $error("connection kind wrong");
   a_appl_len: assert property (
      s_rd(SSB_OFS_APPL_LEN) ##0 $stable(i_appl_param_over_bus)
      |=> o_s_axi_rdata[15:0] == ($past(i_appl_param_over_bus) ?
      16'h0004 : 16'h0000)) else $error("appl length wrong");
   a_accel_hidden: assert property (
      s_rd(SSB_OFS_ACCEL) ##0 (!i_safe_encoder_present
      && !$past(i_safe_encoder_present)) |=> o_s_axi_rdata == 32'h0)
      else $error("accel shown without encoder");
   a_last_err: assert property (
      s_rd(SSB_OFS_LAST_ERR) ##0 $past(i_link_err_valid)
      |=> o_s_axi_rdata == {24'h0, $past(i_link_err, 2)})
      else $error("last error wrong");
   a_write_slverr: assert property (
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_awaddr == SSB_OFS_ACTIVE
      |-> ##[1:20] o_s_axi_bvalid && o_s_axi_bresp == SSB_RESP_SLVERR)
      else $error("write to status not refused");
endmodule
bind ssb_status_bank ssb_status_bank_props u_props (.*);

// ==== tb/ssb_link_master.sv ====
/*
 Behavioural safety fieldbus master: sets the connection id, reports
 link errors. Assumes the bank samples its strobes on the rising edge.
*/
`timescale 1ns/1ns
module ssb_link_master (
   input wire logic i_ref_clk,
   output logic o_conn_reached,
   output logic o_conn_id_valid,
   output logic [15:0] o_conn_id,
   output logic o_link_err_valid,
   output logic [7:0] o_link_err
);
   initial begin
      o_conn_reached = 1'b0;
      o_conn_id_valid = 1'b0;
      o_conn_id = 16'h0000;
      o_link_err_valid = 1'b0;
      o_link_err = 8'h00;
   end
   // ************************************
   // Master actions
   // ************************************
   task automatic connect(input logic [15:0] id);
      @(posedge i_ref_clk);
      o_conn_reached <= 1'b1;
      o_conn_id_valid <= (id != 16'h0000);
      o_conn_id <= id;
      @(posedge i_ref_clk);
      o_conn_id_valid <= 1'b0;
      o_conn_id <= ~id; // Stale id must not look valid
   endtask
   task automatic report_err(input logic [7:0] code);
      @(posedge i_ref_clk);
      o_link_err_valid <= 1'b1;
      o_link_err <= code;
      @(posedge i_ref_clk);
      o_link_err_valid <= 1'b0;
      o_link_err <= ~code;
   endtask
endmodule

// ==== tb/ssb_status_bank_tb.sv ====
/*
 Self-checking bench for the status bank over AXI4-Lite reads and writes.
 Assumes the link master model and the bound checker beside the bank.
*/
`timescale 1ns/1ns
module ssb_status_bank_tb
   import ssb_pkg::*;
();
   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [31:0] wd = 32'h0, func = 32'h0, accel = 32'h0;
   logic enc = 1'b1, appl = 1'b0;
   logic [1:0] brake = 2'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic reached, id_valid, err_valid;
   logic [15:0] conn_id;
   logic [7:0] link_err;
   int bad_count = 0;
   int num_checks = 0;
   always #2 i_ref_clk = ~i_ref_clk;
   ssb_status_bank u_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .i_safe_accel(accel),
      .i_safe_encoder_present(enc), .i_safe_torque_removal(func[0]),
      .i_safe_speed_monitor(func[2:1]), .i_safe_operating_stop(func[3]),
      .i_safe_speed_range({func[14], func[13], func[4]}),
      .i_direction_positive(func[5]), .i_direction_negative(func[6]),
      .i_safety_error(func[7]), .i_safe_cam(func[10:8]),
      .i_limited_acceleration(func[11]),
      .i_safe_accel_range({func[12], func[31], func[30]}),
      .i_limited_speed(func[18:16]), .i_stop_type_one(func[21:19]),
      .i_stop_type_two(func[23:22]), .i_limited_increment(func[26:24]),
      .i_limited_position(func[29:27]), .i_safe_brake_ctrl_state(brake),
      .i_appl_param_over_bus(appl), .i_conn_reached(reached),
      .i_conn_id_valid(id_valid), .i_conn_id(conn_id),
      .i_link_err_valid(err_valid), .i_link_err(link_err));
   ssb_link_master u_master (.i_ref_clk(i_ref_clk), .o_conn_reached(reached),
      .o_conn_id_valid(id_valid), .o_conn_id(conn_id),
      .o_link_err_valid(err_valid), .o_link_err(link_err));
   // ************************************
   // Bus and check tasks
   // ************************************
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic bus_timeout();
      bad_count++;
      $display("mismatch at %0t: bus wait ran out", $time);
      give_verdict();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Ready is looked at before the edge's own updates land
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      bit done = 1'b0;
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(posedge i_ref_clk);
         if (arv && arready)
            arv <= 1'b0;
         if (rready && rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         bus_timeout();
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [1:0] exp);
      bit done = 1'b0;
      awaddr <= a;
      wd <= 32'hffff_ffff;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(posedge i_ref_clk);
         if (awv && awready)
            awv <= 1'b0;
         if (wv && wready)
            wv <= 1'b0;
         if (bready && bvalid) begin
            check({30'h0, bresp}, {30'h0, exp});
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         bus_timeout();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, SSB_RESP_OKAY});
   endtask
   // ************************************
   // Main sequence
   // ************************************
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (4) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      @(posedge i_ref_clk);
      rd_chk(SSB_OFS_ACTIVE, SSB_ACTIVE_RST);
      rd_chk(SSB_OFS_BRAKE, 32'h0);
      rd_chk(SSB_OFS_COMM_LEN, 32'h2);
      rd_chk(SSB_OFS_CONN_KIND, 32'h2);
      rd_chk(SSB_OFS_APPL_LEN, 32'h0);
      rd_chk(SSB_OFS_PROTO_VER, 32'h1);
      // Walk one bit, then all ones; bit 15 has no source
      for (int i = 0; i < 33; i++) begin
         func <= (i == 32) ? 32'hffff_ffff : 32'h1 << i;
         @(posedge i_ref_clk);
         rd_chk(SSB_OFS_ACTIVE, func & 32'hffff_7fff);
      end
      rd_chk(SSB_OFS_ERROR, 32'h1);
      func <= 32'h0;
      @(posedge i_ref_clk);
      rd_chk(SSB_OFS_ERROR, 32'h0);
      for (int b = 3; b >= 0; b--) begin
         brake <= 2'(b);
         @(posedge i_ref_clk);
         rd_chk(SSB_OFS_BRAKE, 32'(b));
      end
      accel <= 32'h8000_0001;
      @(posedge i_ref_clk);
      rd_chk(SSB_OFS_ACCEL, 32'h8000_0001);
      rd_chk(SSB_OFS_ACCEL_VALID, 32'h1);
      enc <= 1'b0;
      @(posedge i_ref_clk);
      rd_chk(SSB_OFS_ACCEL, 32'h0);
      rd_chk(SSB_OFS_ACCEL_VALID, 32'h0);
      appl <= 1'b1;
      @(posedge i_ref_clk);
      rd_chk(SSB_OFS_APPL_LEN, 32'h4);
      u_master.connect(16'hffff);
      rd_chk(SSB_OFS_CONN_ID, 32'hffff);
      u_master.connect(16'h0001);
      rd_chk(SSB_OFS_CONN_ID, 32'h1);
      for (int c = 11; c >= 0; c--) begin
         u_master.report_err(8'(c));
         rd_chk(SSB_OFS_LAST_ERR, 32'(c));
      end
      wr_chk(SSB_OFS_ACTIVE, SSB_RESP_SLVERR);
      wr_chk(SSB_OFS_CONN_ID, SSB_RESP_SLVERR);
      wr_chk(SSB_OFS_COMM_LEN, SSB_RESP_SLVERR);
      rd_chk(SSB_OFS_CONN_ID, 32'h1);
      rd_chk(SSB_OFS_COMM_LEN, 32'h2);
      rd_chk(SSB_OFS_ACTIVE, 32'h0);
      wr_chk(8'h3c, SSB_RESP_DECERR);
      axi_read(8'h3c, d, r);
      check({30'h0, r}, {30'h0, SSB_RESP_DECERR});
      give_verdict();
   end
endmodule
